// >>> hw/spwm_map.svh
// Register offsets, field positions, reset values and ranges of the PWM channel
`ifndef SPWM_MAP_SVH
`define SPWM_MAP_SVH

// Register offsets on the byte-wide register port
`define SPWM_ADDR_CNT_LO     4'h0
`define SPWM_ADDR_CNT_HI     4'h1
`define SPWM_ADDR_DUTY_LO    4'h2
`define SPWM_ADDR_DUTY_HI    4'h3
`define SPWM_ADDR_PER_LO     4'h4
`define SPWM_ADDR_PER_HI     4'h5
`define SPWM_ADDR_CTRL0      4'h6
`define SPWM_ADDR_CTRL1      4'h7
`define SPWM_ADDR_CTRL2      4'h8
`define SPWM_ADDR_CTRL6      4'h9

// Control register 0 fields
`define SPWM_C0_CLKSEL_LSB   0
`define SPWM_C0_CLKSEL_MSB   1
`define SPWM_C0_INTSEL_BIT   2
`define SPWM_C0_POL_BIT      3

// Control register 1 fields
`define SPWM_C1_RUN_BIT      0
`define SPWM_C1_STAT_BIT     1
`define SPWM_C1_ONESHOT_BIT  2

// Control register 2 fields
`define SPWM_C2_STM0_BIT     0
`define SPWM_C2_STM1_BIT     1
`define SPWM_C2_TGE0_BIT     2
`define SPWM_C2_TGE1_BIT     3
`define SPWM_C2_TGSEL_BIT    4

// Control register 6 fields
`define SPWM_C6_CLKSEL_LSB   0
`define SPWM_C6_CLKSEL_MSB   1
`define SPWM_C6_COUPLE_BIT   7

// Reset values
`define SPWM_RST_BYTE        8'h00
`define SPWM_RST_WORD        16'h0000
`define SPWM_RST_PERIOD      16'hffff
`define SPWM_RST_DUTY        16'h0000

// Legal setting ranges
`define SPWM_PERIOD_MIN      16'h0001
`define SPWM_PERIOD_MAX      16'hffff
`define SPWM_DUTY_MAX        16'hfffe

`endif

// >>> hw/spwm_pkg.sv
// Types shared by the PWM channel modules
package spwm_pkg;

   typedef logic [7:0]  spwm_byte_t;
   typedef logic [3:0]  spwm_addr_t;
   typedef logic [15:0] spwm_word_t;

   // External start/stop/clear operating modes
   typedef enum logic [1:0] {
      SPWM_TRIG_SOFT,
      SPWM_TRIG_LEVEL,
      SPWM_TRIG_EDGE,
      SPWM_TRIG_CLEAR
   } spwm_trig_e;

endpackage

// >>> hw/spwm_clkdiv.sv
// Prescaler that makes the falling-edge enable of the count clock
`timescale 1ns/1ps
module spwm_clkdiv #(
   parameter int DIV_W = 15
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   // Division select, divides by two to the power of sel
   input  wire logic [3:0]       div_sel,
   // One-cycle pulse at each falling edge of the count clock
   output logic                  fall_tick
);
   logic [DIV_W-1:0] pre_reg;
   wire  [DIV_W-1:0] pre_mask;

   if (DIV_W < 15)
      $error("spwm_clkdiv: DIV_W must be at least 15");

   // Mask of low bits that must all be ones for a tick
   assign pre_mask  = DIV_W'((32'h1 << div_sel) - 32'h1);
   assign fall_tick = ((pre_reg & pre_mask) == pre_mask);

   // Free-running prescale counter
   always_ff @(posedge clk_sys) begin
      if (!reset_n)
         pre_reg <= '0;
      else
         pre_reg <= pre_reg + DIV_W'(1);
   end
endmodule

// >>> hw/spwm_channel.sv
// Single independent PWM channel with repeat and one-shot operation
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "spwm_map.svh"
module spwm_channel (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                reset_n,
   // Register port
   input  wire spwm_pkg::spwm_addr_t reg_addr,
   input  wire spwm_pkg::spwm_byte_t reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output spwm_pkg::spwm_byte_t     reg_rdata,
   // External trigger pins
   input  wire logic                ext_trig_pin_0,
   input  wire logic                ext_trig_pin_1,
   // PWM output and channel event
   output logic                     pwm_out,
   output logic                     channel_interrupt
);
   import spwm_pkg::*;

   // Software-visible registers
   spwm_word_t duty_reg;
   spwm_word_t period_reg;
   spwm_byte_t control_reg_0;
   spwm_byte_t control_reg_2;
   spwm_byte_t control_reg_6;
   logic       run_request;
   logic       oneshot_select;
   // Channel state
   spwm_word_t counter_reg;
   spwm_word_t duty_buffer;
   spwm_word_t period_buffer;
   logic       running_status;
   logic       output_flag;
   logic       irq_reg;
   spwm_byte_t rdata_reg;
   // Trigger synchronisers and edge history
   logic [1:0] trig_meta_reg;
   logic [1:0] trig_sync_reg;
   logic       trig_prev_reg;

   // One-hot flag of the register that an address names
   function automatic logic [9:0] reg_sel(input spwm_addr_t a);
      logic [9:0] s;
      s = 10'h000;
      if (a == `SPWM_ADDR_CNT_LO)
         s = 10'h001;
      else if (a == `SPWM_ADDR_CNT_HI)
         s = 10'h002;
      else if (a == `SPWM_ADDR_DUTY_LO)
         s = 10'h004;
      else if (a == `SPWM_ADDR_DUTY_HI)
         s = 10'h008;
      else if (a == `SPWM_ADDR_PER_LO)
         s = 10'h010;
      else if (a == `SPWM_ADDR_PER_HI)
         s = 10'h020;
      else if (a == `SPWM_ADDR_CTRL0)
         s = 10'h040;
      else if (a == `SPWM_ADDR_CTRL1)
         s = 10'h080;
      else if (a == `SPWM_ADDR_CTRL2)
         s = 10'h100;
      else if (a == `SPWM_ADDR_CTRL6)
         s = 10'h200;
      // Unmapped addresses select nothing, so writes there are ignored
      reg_sel = s;
   endfunction

   // Write decode shares the address select with the read multiplexer
   wire [9:0] addr_sel = reg_sel(reg_addr);
   wire wr_cnt    = reg_wr && (addr_sel[0] || addr_sel[1]);
   wire wr_duty_l = reg_wr && addr_sel[2];
   wire wr_duty_h = reg_wr && addr_sel[3];
   wire wr_per_l  = reg_wr && addr_sel[4];
   wire wr_per_h  = reg_wr && addr_sel[5];
   wire wr_c0     = reg_wr && addr_sel[6];
   wire wr_c1     = reg_wr && addr_sel[7];
   wire wr_c2     = reg_wr && addr_sel[8];
   wire wr_c6     = reg_wr && addr_sel[9];

   // Count clock select spans both control registers
   wire [3:0] clk_sel = {control_reg_6[`SPWM_C6_CLKSEL_MSB:
                                       `SPWM_C6_CLKSEL_LSB],
                         control_reg_0[`SPWM_C0_CLKSEL_MSB:
                                       `SPWM_C0_CLKSEL_LSB]};
   // Count enable at each falling edge of the selected clock
   wire       cnt_tick;

   spwm_clkdiv #(
      .DIV_W   (15)
   ) u_div (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .div_sel   (clk_sel),
      .fall_tick (cnt_tick)
   );

   // Control field decode
   wire int_on_duty = control_reg_0[`SPWM_C0_INTSEL_BIT];
   wire pol_invert  = control_reg_0[`SPWM_C0_POL_BIT];
   wire pair_couple_select = control_reg_6[`SPWM_C6_COUPLE_BIT];
   wire ext_trig_mode_lo = control_reg_2[`SPWM_C2_STM0_BIT];
   wire ext_trig_mode_hi = control_reg_2[`SPWM_C2_STM1_BIT];
   wire trig_edge_sel_0  = control_reg_2[`SPWM_C2_TGE0_BIT];
   wire trig_edge_sel_1  = control_reg_2[`SPWM_C2_TGE1_BIT];
   wire trig_pin_select  = control_reg_2[`SPWM_C2_TGSEL_BIT];
   wire spwm_trig_e trig_mode =
      spwm_trig_e'({ext_trig_mode_hi, ext_trig_mode_lo});

   // Selected trigger level and its edges
   wire trig_lvl  = trig_pin_select ? trig_sync_reg[1] : trig_sync_reg[0];
   wire trig_rise = trig_lvl && !trig_prev_reg;
   wire trig_fall = !trig_lvl && trig_prev_reg;
   wire tge_01    = !trig_edge_sel_1 && trig_edge_sel_0;
   wire tge_10    = trig_edge_sel_1 && !trig_edge_sel_0;

   // External start, stop/clear and clear events per mode
   wire lvl_mode  = (trig_mode == SPWM_TRIG_LEVEL);
   wire edge_mode = (trig_mode == SPWM_TRIG_EDGE);
   wire clr_mode  = (trig_mode == SPWM_TRIG_CLEAR);
   wire ext_start = (lvl_mode  && tge_01 && trig_lvl && !run_request) ||
                    (lvl_mode  && tge_10 && !trig_lvl && !run_request) ||
                    (edge_mode && tge_01 && trig_rise) ||
                    (edge_mode && tge_10 && trig_fall);
   wire ext_stop  = (lvl_mode  && tge_01 && !trig_lvl && run_request) ||
                    (lvl_mode  && tge_10 && trig_lvl && run_request) ||
                    (edge_mode && tge_01 && trig_fall) ||
                    (edge_mode && tge_10 && trig_rise);
   wire ext_clear = clr_mode && ((trig_edge_sel_0 && trig_fall) ||
                                 (trig_edge_sel_1 && trig_rise));
   // Edge mode with both or neither trigger bit keeps the channel idle
   wire pwm_block = edge_mode && (trig_edge_sel_0 == trig_edge_sel_1);

   // Match detection against the active buffers
   wire duty_hit   = (counter_reg == duty_buffer);
   wire period_hit = (counter_reg == period_buffer);
   wire tick_ok    = cnt_tick && !pwm_block;
   wire step       = tick_ok && running_status;
   wire wrap       = step && period_hit;
   wire cnt_clear  = wr_cnt || ext_stop || ext_clear;

   // Run bit: software set wins over hardware clear
   wire sw_run_set = wr_c1 && reg_wdata[`SPWM_C1_RUN_BIT];
   wire sw_run_clr = wr_c1 && !reg_wdata[`SPWM_C1_RUN_BIT];
   wire hw_run_clr = (wrap && oneshot_select) || ext_stop;
   wire run_next   = sw_run_set || ext_start ||
                     (run_request && !sw_run_clr && !hw_run_clr);

   // Status: first tick after run raises it, tick after clear drops it
   wire status_next = tick_ok ?
                      (running_status ? (run_request && !hw_run_clr)
                                      : run_request)
                      : (running_status && !(wrap && oneshot_select));

   // Counter next value
   wire spwm_word_t counter_next =
      cnt_clear ? `SPWM_RST_WORD :
      wrap      ? `SPWM_RST_WORD :
      step      ? counter_reg + 16'h0001 :
                  counter_reg;

   // Output flag next value
   wire flag_next = cnt_clear       ? 1'b1 :
                    wrap            ? 1'b1 :
                    step && duty_hit ? 1'b0 :
                                      output_flag;

   // Write data assembled into sixteen-bit registers
   wire spwm_word_t duty_wr_val =
      wr_duty_l ? {duty_reg[15:8], reg_wdata} :
      wr_duty_h ? {reg_wdata, duty_reg[7:0]} : duty_reg;
   wire spwm_word_t per_wr_val =
      wr_per_l ? {period_reg[15:8], reg_wdata} :
      wr_per_h ? {reg_wdata, period_reg[7:0]} : period_reg;
   // Buffers track writes only while the counter is idle
   wire stopped = !running_status;

   // Buffers load on wrap or follow writes while the channel is stopped
   wire spwm_word_t duty_buf_next =
      wrap ? duty_reg :
      (stopped && (wr_duty_l || wr_duty_h)) ? duty_wr_val :
      duty_buffer;
   wire spwm_word_t per_buf_next =
      wrap ? period_reg :
      (stopped && (wr_per_l || wr_per_h)) ? per_wr_val :
      period_buffer;

   // Interrupt on the selected match while counting
   wire irq_next = int_on_duty ? (step && duty_hit)
                               : wrap;

   // Read data multiplexer
   wire spwm_byte_t ctrl1_rd = {5'h00, oneshot_select, running_status,
                                run_request};
   wire spwm_byte_t rd_mux =
      addr_sel[0] ? counter_reg[7:0]  :
      addr_sel[1] ? counter_reg[15:8] :
      addr_sel[2] ? duty_reg[7:0]     :
      addr_sel[3] ? duty_reg[15:8]    :
      addr_sel[4] ? period_reg[7:0]   :
      addr_sel[5] ? period_reg[15:8]  :
      addr_sel[6] ? control_reg_0     :
      addr_sel[7] ? ctrl1_rd          :
      addr_sel[8] ? control_reg_2     :
      addr_sel[9] ? control_reg_6     :
                    `SPWM_RST_BYTE;

   // Pin synchronisers: first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         trig_meta_reg <= 2'h0;
         trig_sync_reg <= 2'h0;
         trig_prev_reg <= 1'b0;
      end else begin
         trig_meta_reg <= {ext_trig_pin_1, ext_trig_pin_0};
         trig_sync_reg <= trig_meta_reg;
         trig_prev_reg <= trig_lvl;
      end
   end

   // Software configuration registers
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         duty_reg       <= `SPWM_RST_DUTY;
         period_reg     <= `SPWM_RST_PERIOD;
         control_reg_0  <= `SPWM_RST_BYTE;
         control_reg_2  <= `SPWM_RST_BYTE;
         control_reg_6  <= `SPWM_RST_BYTE;
         oneshot_select <= 1'b0;
      end else begin
         duty_reg   <= duty_wr_val;
         period_reg <= per_wr_val;
         if (wr_c0)
            control_reg_0 <= reg_wdata;
         if (wr_c2)
            control_reg_2 <= reg_wdata;
         if (wr_c6)
            control_reg_6 <= reg_wdata;
         if (wr_c1)
            oneshot_select <= reg_wdata[`SPWM_C1_ONESHOT_BIT];
      end
   end

   // Counter, buffers and run control
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         counter_reg    <= `SPWM_RST_WORD;
         duty_buffer    <= `SPWM_RST_DUTY;
         period_buffer  <= `SPWM_RST_PERIOD;
         run_request    <= 1'b0;
         running_status <= 1'b0;
         output_flag    <= 1'b0;
      end else begin
         counter_reg    <= counter_next;
         duty_buffer    <= duty_buf_next;
         period_buffer  <= per_buf_next;
         run_request    <= run_next;
         running_status <= status_next;
         output_flag    <= flag_next;
      end
   end

   // Output pin, interrupt pulse and read data
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pwm_out   <= 1'b0;
         irq_reg   <= 1'b0;
         rdata_reg <= `SPWM_RST_BYTE;
      end else begin
         pwm_out   <= flag_next ^ pol_invert;
         irq_reg   <= irq_next;
         rdata_reg <= reg_rd ? rd_mux : `SPWM_RST_BYTE;
      end
   end

   assign channel_interrupt = irq_reg;
   assign reg_rdata         = rdata_reg;

   // Coupled operation is not built; the bit only reads back
   wire unused_couple = pair_couple_select;
endmodule

// >>> sim/spwm_channel_props.sv
// Checker of the PWM channel register port, output pin and interrupt
`timescale 1ns/1ps
module spwm_channel_props (
   // Clock and reset
   input wire logic                 clk_sys,
   input wire logic                 reset_n,
   // Register port
   input wire spwm_pkg::spwm_addr_t reg_addr,
   input wire spwm_pkg::spwm_byte_t reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire spwm_pkg::spwm_byte_t reg_rdata,
   // Pins
   input wire logic                 ext_trig_pin_0,
   input wire logic                 ext_trig_pin_1,
   input wire logic                 pwm_out,
   input wire logic                 channel_interrupt
);
   import spwm_pkg::*;
   spwm_byte_t shadow [16];
   spwm_byte_t exp_q;
   spwm_addr_t rd_addr_q;
   logic       rd_q;
   logic       armed;
   wire        pol = shadow[6][3];

   // Bits that read back what software wrote
   function automatic spwm_byte_t rw_mask(input spwm_addr_t a);
      case (a)
         4'h2, 4'h3, 4'h4, 4'h5: rw_mask = 8'hff;
         4'h6: rw_mask = 8'h0f;
         4'h7: rw_mask = 8'h04;
         4'h8: rw_mask = 8'h1f;
         4'h9: rw_mask = 8'h83;
         default: rw_mask = 8'h00;
      endcase
   endfunction

   // Shadow of written fields, read tracking, start arming
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         for (int i = 0; i < 16; i++)
            shadow[i] <= (i == 4 || i == 5) ? 8'hff : 8'h00;
         rd_q  <= 1'b0;
         armed <= 1'b0;
      end else begin
         if (reg_wr)
            shadow[reg_addr] <= reg_wdata;
         rd_q      <= reg_rd;
         rd_addr_q <= reg_addr;
         exp_q     <= shadow[reg_addr] & rw_mask(reg_addr);
         if (reg_wr && (reg_addr == 4'h8 ||
                        (reg_addr == 4'h7 && reg_wdata[0])))
            armed <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   rdata_idle_a: assert property (
      !rd_q |-> reg_rdata == 8'h00) else $error("Read data not idle");
   unmapped_rd_a: assert property (
      reg_rd && reg_addr > 4'h9 |=> reg_rdata == 8'h00)
      else $error("Unmapped read not zero");
   reg_readback_a: assert property (
      rd_q |-> (reg_rdata & rw_mask(rd_addr_q)) == exp_q)
      else $error("Register readback wrong");
   reset_quiet_a: assert property (disable iff (1'b0)
      !reset_n |=> !pwm_out && !channel_interrupt && reg_rdata == 8'h00)
      else $error("Outputs active in reset");
   irq_pulse_a: assert property (
      channel_interrupt |=> !channel_interrupt) else $error("Long interrupt");
   cnt_clear_a: assert property (
      reg_wr && reg_addr <= 4'h1 |=> pwm_out == !pol)
      else $error("Counter write left flag low");
   idle_out_a: assert property (
      !armed && !reg_wr && !$past(reg_wr) |=> $stable(pwm_out))
      else $error("Output moved while never started");
   irq_armed_a: assert property (
      channel_interrupt |-> armed) else $error("Interrupt before any start");
endmodule

bind spwm_channel spwm_channel_props i_props (.clk_sys(clk_sys),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ext_trig_pin_0(ext_trig_pin_0), .ext_trig_pin_1(ext_trig_pin_1),
   .pwm_out(pwm_out), .channel_interrupt(channel_interrupt));

// >>> sim/spwm_pin_model.sv
// Far side model: trigger pin driver and output pin timing monitor
`timescale 1ns/1ps
module spwm_pin_model (
   // Clock
   input  wire logic   clk_sys,
   // Commands from the bench
   input  wire logic   trig_level,
   input  wire logic   trig_sel,
   // Channel pins
   input  wire logic   pwm_out,
   output logic        ext_trig_pin_0,
   output logic        ext_trig_pin_1,
   // Measured output timing in system clocks
   output int unsigned high_len,
   output int unsigned per_len,
   output int unsigned rises
);
   logic        prev    = 1'b0;
   int unsigned run_len = 0;

   // Unselected pin rests low, selected pin follows the command
   assign ext_trig_pin_0 = !trig_sel && trig_level;
   assign ext_trig_pin_1 = trig_sel && trig_level;

   // High phase length and rise to rise period; count restarts at one on each rise
   always @(posedge clk_sys) begin
      prev    <= pwm_out;
      run_len <= run_len + 1;
      if (pwm_out && !prev) begin
         per_len <= run_len;
         run_len <= 1;
         rises   <= rises + 1;
      end
      if (!pwm_out && prev)
         high_len <= run_len;
   end
endmodule

// >>> sim/tb_spwm_channel.sv
// Testbench of the single PWM channel
`timescale 1ns/1ps
module tb_spwm_channel;
   import spwm_pkg::*;
   logic        clk_sys    = 1'b0;
   logic        reset_n    = 1'b0;
   spwm_addr_t  reg_addr   = 4'h0;
   spwm_byte_t  reg_wdata  = 8'h00;
   logic        reg_wr     = 1'b0;
   logic        reg_rd     = 1'b0;
   logic        trig_level = 1'b0;
   logic        trig_sel   = 1'b0;
   spwm_byte_t  reg_rdata, d, c1;
   logic        pwm_out, channel_interrupt, pin0, pin1;
   int unsigned high_len, per_len, rises, n0;
   int unsigned irq_cnt     = 0;
   int          error_cnt   = 0;
   int          checks_done = 0;

   // Clock and interrupt count away from the sampling edge
   always #4 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
      if (channel_interrupt === 1'b1)
         irq_cnt++;

   spwm_channel i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trig_pin_0(pin0),
      .ext_trig_pin_1(pin1), .pwm_out(pwm_out),
      .channel_interrupt(channel_interrupt));
   spwm_pin_model i_pins (.clk_sys(clk_sys), .trig_level(trig_level),
      .trig_sel(trig_sel), .pwm_out(pwm_out), .ext_trig_pin_0(pin0),
      .ext_trig_pin_1(pin1), .high_len(high_len), .per_len(per_len),
      .rises(rises));

   task automatic wr(input spwm_addr_t a, input spwm_byte_t v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input spwm_addr_t a, output spwm_byte_t v);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge clk_sys);
   endtask
   task automatic chk_b(input string n, input spwm_byte_t e, spwm_byte_t g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_n(input string n, input int unsigned e, g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic rdchk(input string n, spwm_addr_t a, spwm_byte_t m, e);
      rd(a, d);
      chk_b(n, e, d & m);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wait_rise;
      int unsigned r;
      r = rises;
      for (int i = 0; i < 300 && rises == r; i++)
         @(posedge clk_sys);
   endtask

   task automatic t_reset;
      wr(4'hf, 8'h5a);
      for (int i = 0; i < 16; i++)
         rdchk("reset value", 4'(i), 8'hff,
               (i == 4 || i == 5) ? 8'hff : 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_shape;
      wr(4'h4, 8'h05);
      wr(4'h5, 8'h00);
      wr(4'h2, 8'h02);
      wr(4'h7, 8'h01);
      cyc(30);
      chk_n("period", 6, per_len);
      chk_n("high time", 3, high_len);
      n0 = irq_cnt;
      cyc(60);
      chk_n("period irqs", 10, irq_cnt - n0);
      wait_rise;
      wr(4'h2, 8'h01);
      cyc(2);
      chk_n("old duty", 3, high_len);
      cyc(12);
      chk_n("new duty", 2, high_len);
      wr(4'h6, 8'h01);
      cyc(40);
      chk_n("div 2 period", 12, per_len);
      wr(4'h6, 8'h00);
      wr(4'h9, 8'h01);
      cyc(250);
      chk_n("div 16 period", 96, per_len);
      wr(4'h9, 8'h00);
      wr(4'h6, 8'h04);
      n0 = irq_cnt;
      cyc(60);
      chk_n("duty irqs", 10, irq_cnt - n0);
      wr(4'h6, 8'h08);
      cyc(20);
      chk_n("inverted high", 4, high_len);
      wr(4'h6, 8'h00);
      $display("t_shape done");
   endtask
   task automatic t_stop;
      wr(4'h4, 8'hff);
      wr(4'h5, 8'hff);
      cyc(8);
      wr(4'h7, 8'h00);
      cyc(4);
      rdchk("stopped ctrl1", 4'h7, 8'hff, 8'h00);
      wr(4'h1, 8'h00);
      rdchk("cleared count", 4'h0, 8'hff, 8'h00);
      chk_b("flag after clear", 8'h01, {7'h00, pwm_out});
      wr(4'h7, 8'h01);
      cyc(20);
      wr(4'h7, 8'h00);
      cyc(4);
      rd(4'h0, c1);
      cyc(6);
      rdchk("held count", 4'h0, 8'hff, c1);
      wr(4'h7, 8'h01);
      cyc(10);
      wr(4'h7, 8'h00);
      cyc(4);
      rd(4'h0, d);
      chk_n("resumed gain", 1, d > c1 + 8'd8 && d < c1 + 8'd16);
      $display("t_stop done");
   endtask
   task automatic t_oneshot;
      wr(4'h4, 8'h03);
      wr(4'h5, 8'h00);
      wr(4'h2, 8'h00);
      wr(4'h0, 8'h00);
      n0 = irq_cnt;
      wr(4'h7, 8'h05);
      cyc(30);
      chk_n("single shot irqs", 1, irq_cnt - n0);
      rdchk("shot ended ctrl1", 4'h7, 8'hff, 8'h04);
      wr(4'h7, 8'h05);
      cyc(30);
      chk_n("second shot irqs", 2, irq_cnt - n0);
      wr(4'h7, 8'h00);
      $display("t_oneshot done");
   endtask
   task automatic t_ext;
      spwm_byte_t modes [3] = '{8'h05, 8'h06, 8'h15};
      for (int i = 0; i < 3; i++) begin
         wr(4'h8, modes[i]);
         trig_sel   <= modes[i][4];
         trig_level <= 1'b1;
         cyc(10);
         rdchk("ext started", 4'h7, 8'h02, 8'h02);
         trig_level <= 1'b0;
         cyc(10);
         rdchk("ext stopped", 4'h7, 8'h02, 8'h00);
         rdchk("ext cleared", 4'h0, 8'hff, 8'h00);
      end
      wr(4'h8, 8'h00);
      $display("t_ext done");
   endtask
   task automatic t_clear;
      trig_sel <= 1'b0;
      wr(4'h4, 8'hff);
      wr(4'h5, 8'hff);
      wr(4'h8, 8'h07);
      wr(4'h0, 8'h00);
      wr(4'h7, 8'h01);
      cyc(20);
      trig_level <= 1'b1;
      cyc(10);
      rd(4'h0, d);
      chk_n("rise ignored", 1, d > 8'd25);
      trig_level <= 1'b0;
      cyc(4);
      rd(4'h0, d);
      chk_n("fall cleared", 1, d < 8'd8);
      rdchk("clear keeps run", 4'h7, 8'h03, 8'h03);
      wr(4'h7, 8'h00);
      wr(4'h8, 8'h00);
      $display("t_clear done");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Main sequence after a twelve cycle reset
   initial begin
      cyc(12);
      reset_n <= 1'b1;
      t_reset;
      t_shape;
      t_stop;
      t_oneshot;
      t_ext;
      t_clear;
      end_sim;
   end
   // Watchdog against a hang
   initial begin
      #100000;
      error_cnt++;
      $display("Error watchdog expected finish seen timeout");
      end_sim;
   end
endmodule
